// ---- core/bcd_params.svh ----
// Addresses, field positions, reset values and timing of the BCD corrector.
`ifndef BCD_PARAMS_SVH
`define BCD_PARAMS_SVH

`define BCD_ADDR_W          20
`define BCD_ADJ_ADDR        20'hF00FE
`define BCD_DATA_W          8
`define BCD_LO_NIB_LSB      0
`define BCD_HI_NIB_LSB      4
`define BCD_NIBBLE_LIMIT    4'h9
`define BCD_NIBBLE_FIX      4'h6
`define BCD_LO_STEP         8'h06
`define BCD_RDATA_RESET     8'h00
`define BCD_READ_LATENCY    1

`endif

// ---- core/bcd_pkg.sv ----
// Types shared by the BCD correction unit.
`default_nettype none
package bcd_pkg;

   typedef logic [19:0] addr_t;
   typedef logic [7:0]  byte_t;
   typedef logic [3:0]  nibble_t;

   typedef enum {
      ACC_NONE,
      ACC_READ,
      ACC_REFUSED
   } access_e;

endpackage : bcd_pkg
`default_nettype wire

// ---- core/bcd_adjust_calc.sv ----
// Combinational correction value from the accumulator and the two flags.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_params.svh"

module bcd_adjust_calc (
   input  wire logic                    carryFlag,
   input  wire logic                    halfCarryFlag,
   input  wire logic [`BCD_DATA_W-1:0]  accumulator,
   output logic      [`BCD_DATA_W-1:0]  correction
);

   bcd_pkg::nibble_t loNib;
   bcd_pkg::nibble_t hiNib;
   bcd_pkg::nibble_t loFix;
   bcd_pkg::nibble_t hiFix;
   logic [`BCD_DATA_W:0] lowAdjusted;

   always_comb begin
      loNib = accumulator[`BCD_LO_NIB_LSB +: 4];
      // A low nibble past nine or a half carry calls for six below.
      if (halfCarryFlag || (loNib > `BCD_NIBBLE_LIMIT)) begin
         loFix = `BCD_NIBBLE_FIX;
      end else begin
         loFix = 4'h0;
      end
      // The high nibble is judged after the low fix, since adding six
      // below may carry into it, or out of the byte altogether.
      lowAdjusted = {1'b0, accumulator} + {5'h00, loFix};
      hiNib = lowAdjusted[`BCD_HI_NIB_LSB +: 4];
      if (carryFlag || lowAdjusted[`BCD_DATA_W] ||
          (hiNib > `BCD_NIBBLE_LIMIT)) begin
         hiFix = `BCD_NIBBLE_FIX;
      end else begin
         hiFix = 4'h0;
      end
      // One value serves both directions: added after a sum, subtracted
      // after a difference.
      correction = {hiFix, loFix};
   end

endmodule : bcd_adjust_calc
`default_nettype wire

// ---- core/bcd_correction_unit.sv ----
// Decimal-adjust value register, read over the core's data memory port.
//
// How it works
// - Supplies value that turns binary result into BCD.
// - Value computed live from accumulator and flags.
// - Only 8-bit reads; writes store nothing and raise accessError.
// - Register sits at fixed address F00FE.
// - Contents cleared to 00 at reset, meaningless until first read.
// - Adding value gives decimal sum and carry.
// - Subtracting value gives decimal difference and borrow.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_params.svh"

module bcd_correction_unit (
   input  wire logic                    clk,
   input  wire logic                    rstn,
   input  wire logic [`BCD_ADDR_W-1:0]  memAddr,
   input  wire logic                    memRead,
   input  wire logic                    memWrite,
   input  wire logic                    memByte,
   input  wire logic [`BCD_DATA_W-1:0]  accumulator,
   input  wire logic                    carryFlag,
   input  wire logic                    halfCarryFlag,
   output logic      [`BCD_DATA_W-1:0]  rdData,
   output logic                         rdValid,
   output logic                         accessError
);

   ////////////////////////////////////////////////////////////////////////
   // Access decode.

   function automatic bcd_pkg::access_e decodeAccess(
      input logic [`BCD_ADDR_W-1:0] addr,
      input logic                   rd,
      input logic                   wr,
      input logic                   byteWide
   );
      bcd_pkg::access_e kind;
      kind = bcd_pkg::ACC_NONE;
      if (addr == `BCD_ADJ_ADDR) begin
         if (rd && byteWide && !wr) begin
            kind = bcd_pkg::ACC_READ;
         end else if (rd || wr) begin
            kind = bcd_pkg::ACC_REFUSED;
         end
      end
      return kind;
   endfunction : decodeAccess

   // Reference value, used to cross-check the datapath in assertions.
   function automatic logic [`BCD_DATA_W-1:0] refCorrection(
      input logic [`BCD_DATA_W-1:0] a,
      input logic                   carryIn,
      input logic                   halfIn
   );
      logic [`BCD_DATA_W:0] t;
      logic                 lo;
      logic                 hi;
      lo = halfIn || (a[3:0] > 4'h9);
      t  = {1'b0, a} + (lo ? 9'h006 : 9'h000);
      hi = carryIn || t[8] || (t[7:4] > 4'h9);
      return {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
   endfunction : refCorrection

   bcd_pkg::access_e      accessKind;
   logic [`BCD_DATA_W-1:0] liveCorrection;

   assign accessKind = decodeAccess(memAddr, memRead, memWrite, memByte);

   // The value is formed from whatever the accumulator and flags hold in
   // the read cycle; nothing is latched at the arithmetic instruction, so
   // an interrupt between the two steps must preserve them.
   bcd_adjust_calc calc (
      .carryFlag     (carryFlag),
      .halfCarryFlag (halfCarryFlag),
      .accumulator   (accumulator),
      .correction    (liveCorrection)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read answer registers.

   logic [`BCD_DATA_W-1:0] rdData_reg;
   logic [`BCD_DATA_W-1:0] rdData_next;
   logic                   rdValid_reg;
   logic                   rdValid_next;
   logic                   accessError_reg;
   logic                   accessError_next;

   always_comb begin
      rdData_next      = rdData_reg;
      rdValid_next     = 1'b0;
      accessError_next = 1'b0;
      unique case (accessKind)
         bcd_pkg::ACC_READ: begin
            rdData_next  = liveCorrection;
            rdValid_next = 1'b1;
         end
         bcd_pkg::ACC_REFUSED: begin
            // A write or wide access stores nothing and returns nothing.
            accessError_next = 1'b1;
         end
         bcd_pkg::ACC_NONE: begin
            rdData_next = rdData_reg;
         end
      endcase
   end

   // The data register has no meaningful content until the first read;
   // it is cleared only so the output is never unknown.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData_reg      <= `BCD_RDATA_RESET;
         rdValid_reg     <= 1'b0;
         accessError_reg <= 1'b0;
      end else begin
         rdData_reg      <= rdData_next;
         rdValid_reg     <= rdValid_next;
         accessError_reg <= accessError_next;
      end
   end

   assign rdData      = rdData_reg;
   assign rdValid     = rdValid_reg;
   assign accessError = accessError_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   property p_nibbles_are_fixes;
      @(posedge clk) disable iff (!rstn)
      rdValid |-> ((rdData[3:0] == 4'h0) || (rdData[3:0] == 4'h6)) &&
                  ((rdData[7:4] == 4'h0) || (rdData[7:4] == 4'h6));
   endproperty
   a_nibbles_are_fixes: assert property (p_nibbles_are_fixes)
      else $error("correction nibble is neither 0 nor 6");

   property p_live_value;
      @(posedge clk) disable iff (!rstn)
      rdValid |-> rdData == refCorrection($past(accumulator),
                                          $past(carryFlag),
                                          $past(halfCarryFlag));
   endproperty
   a_live_value: assert property (p_live_value)
      else $error("read value does not follow accumulator and flags");

   property p_refused_silent;
      @(posedge clk) disable iff (!rstn)
      (memAddr == `BCD_ADJ_ADDR && (memWrite || (memRead && !memByte)))
      |=> !rdValid && accessError && $stable(rdData);
   endproperty
   a_refused_silent: assert property (p_refused_silent)
      else $error("refused access changed or returned data");

   property p_address_only;
      @(posedge clk) disable iff (!rstn)
      rdValid |-> $past(memAddr) == `BCD_ADJ_ADDR && $past(memRead) &&
                  $past(memByte);
   endproperty
   a_address_only: assert property (p_address_only)
      else $error("answer without a byte read at the register address");

   property p_quiet_after_reset;
      @(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> !rdValid && !accessError;
   endproperty
   a_quiet_after_reset: assert property (p_quiet_after_reset)
      else $error("answer present at the first edge after reset");

   property p_add_digit_fix;
      @(posedge clk) disable iff (!rstn)
      rdValid && !$past(carryFlag) && !$past(halfCarryFlag) &&
      ($past(accumulator) <= 8'h99) && ($past(accumulator[3:0]) <= 4'h9)
      |-> rdData == 8'h00;
   endproperty
   a_add_digit_fix: assert property (p_add_digit_fix)
      else $error("valid decimal sum given a nonzero correction");

   property p_sub_borrow_fix;
      @(posedge clk) disable iff (!rstn)
      rdValid && $past(halfCarryFlag) && !$past(carryFlag) &&
      ($past(accumulator[7:4]) < 4'h9)
      |-> rdData == `BCD_LO_STEP;
   endproperty
   a_sub_borrow_fix: assert property (p_sub_borrow_fix)
      else $error("low borrow did not give correction 06");

   property p_carry_high_six;
      @(posedge clk) disable iff (!rstn)
      memRead && memByte && !memWrite && memAddr == `BCD_ADJ_ADDR &&
      carryFlag |=> rdValid && rdData[7:4] == 4'h6;
   endproperty
   a_carry_high_six: assert property (p_carry_high_six)
      else $error("carry set but high nibble fix missing");

   property p_half_carry_low_six;
      @(posedge clk) disable iff (!rstn)
      memRead && memByte && !memWrite && memAddr == `BCD_ADJ_ADDR &&
      halfCarryFlag |=> rdValid && rdData[3:0] == 4'h6;
   endproperty
   a_half_carry_low_six: assert property (p_half_carry_low_six)
      else $error("half carry set but low nibble fix missing");

   property p_read_answered;
      @(posedge clk) disable iff (!rstn)
      memRead && memByte && !memWrite && memAddr == `BCD_ADJ_ADDR
      |=> rdValid && !accessError;
   endproperty
   a_read_answered: assert property (p_read_answered)
      else $error("byte read of the register got no answer");

   // Any other address belongs to other blocks, so no pulse may follow.
   property p_other_address_quiet;
      @(posedge clk) disable iff (!rstn)
      memAddr != `BCD_ADJ_ADDR |=> !rdValid && !accessError;
   endproperty
   a_other_address_quiet: assert property (p_other_address_quiet)
      else $error("access to another address was answered");

   property p_data_holds;
      @(posedge clk) disable iff (!rstn)
      !rdValid |-> $stable(rdData);
   endproperty
   a_data_holds: assert property (p_data_holds)
      else $error("read data changed without a read");

endmodule : bcd_correction_unit
`default_nettype wire

// ---- dv/cpu_core_model.sv ----
// Core model: accumulator, flags and data memory accesses.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_params.svh"
module cpu_core_model (
   input  wire logic           clk,
   input  wire bcd_pkg::byte_t rdData,
   input  wire logic           rdValid,
   input  wire logic           accessError,
   output var  bcd_pkg::addr_t memAddr,
   output var  logic           memRead,
   output var  logic           memWrite,
   output var  logic           memByte,
   output var  bcd_pkg::byte_t accumulator,
   output var  logic           carryFlag,
   output var  logic           halfCarryFlag
);
   bcd_pkg::byte_t seenData;
   logic           seenValid;
   logic           seenError;
   initial begin
      {memAddr, memRead, memWrite, memByte} = '0;
      {accumulator, carryFlag, halfCarryFlag} = '0;
   end
   task automatic setState(input bcd_pkg::byte_t a, input logic c, h);
      @(posedge clk);
      #1;
      accumulator = a;
      carryFlag = c;
      halfCarryFlag = h;
   endtask : setState
   // The adjust step keeps an earlier carry, so a sum like 22H+66H stays
   // carried although the binary add itself does not overflow.
   task automatic arith(input bcd_pkg::byte_t b, input logic sub, keepCarry);
      logic [8:0] r;
      logic       h;
      r = sub ? {1'b0, accumulator} - b : {1'b0, accumulator} + b;
      h = sub ? accumulator[3:0] < b[3:0]
              : {1'b0, accumulator[3:0]} + b[3:0] > 5'h0F;
      setState(r[7:0], r[8] | (keepCarry & carryFlag), h);
   endtask : arith
   task automatic access(input bcd_pkg::addr_t a, input logic rd, wr, bw);
      @(posedge clk);
      #1;
      memAddr = a;
      memRead = rd;
      memWrite = wr;
      memByte = bw;
      @(posedge clk);
      #1;
      seenData = rdData;
      seenValid = rdValid;
      seenError = accessError;
      {memAddr, memRead, memWrite} = '0;
   endtask : access
endmodule : cpu_core_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Testbench: decimal add and subtract through the correction register.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_params.svh"
module tb_top;
   logic clk, rstn, memRead, memWrite, memByte, cf, hc, rdValid, accErr;
   bcd_pkg::addr_t memAddr;
   bcd_pkg::byte_t acc, rdData;
   int fails, testsRun;
   localparam bcd_pkg::addr_t Adj = `BCD_ADJ_ADDR;
   initial clk = 1'b0;
   always #10 clk = ~clk;
   bcd_correction_unit dut_u (.clk(clk), .rstn(rstn), .memAddr(memAddr),
      .memRead(memRead), .memWrite(memWrite), .memByte(memByte),
      .accumulator(acc), .carryFlag(cf), .halfCarryFlag(hc),
      .rdData(rdData), .rdValid(rdValid), .accessError(accErr));
   cpu_core_model core_u (.clk(clk), .rdData(rdData), .rdValid(rdValid),
      .accessError(accErr), .memAddr(memAddr), .memRead(memRead),
      .memWrite(memWrite), .memByte(memByte), .accumulator(acc),
      .carryFlag(cf), .halfCarryFlag(hc));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input bcd_pkg::byte_t seen, exp);
      testsRun++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   function automatic bcd_pkg::byte_t flags();
      return {6'h00, core_u.seenValid, core_u.seenError};
   endfunction : flags
   function automatic bcd_pkg::byte_t toBcd(input int n);
      return {4'(n / 10 % 10), 4'(n % 10)};
   endfunction : toBcd
   task automatic readAdj();
      core_u.access(Adj, 1'b1, 1'b0, 1'b1);
      check(flags(), 8'h02);
   endtask : readAdj
   task automatic decimalOp(input int x, y, input logic sub,
                            input bcd_pkg::byte_t corr);
      core_u.setState(toBcd(x), 1'b0, 1'b0);
      core_u.arith(toBcd(y), sub, 1'b0);
      readAdj();
      check(core_u.seenData, corr);
      core_u.arith(core_u.seenData, sub, 1'b1);
      check(acc, toBcd(sub ? (x - y + 100) % 100 : (x + y) % 100));
      check({7'h00, cf}, {7'h00, sub ? x < y : x + y > 99});
   endtask : decimalOp
   ////////////////////////////////////////////////////////////////////////
   task automatic testAdd();
      decimalOp(99, 89, 1'b0, 8'h66);
      decimalOp(85, 15, 1'b0, 8'h66);
      decimalOp(80, 80, 1'b0, 8'h60);
      decimalOp(45, 45, 1'b0, 8'h06);
      decimalOp(12, 34, 1'b0, 8'h00);
   endtask : testAdd
   task automatic testSub();
      decimalOp(91, 52, 1'b1, 8'h06);
      decimalOp(10, 20, 1'b1, 8'h60);
      decimalOp(0, 1, 1'b1, 8'h66);
      decimalOp(50, 49, 1'b1, 8'h06);
      decimalOp(45, 23, 1'b1, 8'h00);
   endtask : testSub
   // The same register must follow the flags with no arithmetic between.
   task automatic testLive();
      core_u.setState(8'h00, 1'b1, 1'b0);
      readAdj();
      check(core_u.seenData, 8'h60);
      core_u.setState(8'h3F, 1'b0, 1'b1);
      readAdj();
      check(core_u.seenData, 8'h06);
   endtask : testLive
   task automatic testRefused();
      core_u.setState(8'h22, 1'b1, 1'b1);
      readAdj();
      core_u.access(Adj, 1'b0, 1'b1, 1'b1);
      check(flags(), 8'h01);
      core_u.access(Adj, 1'b1, 1'b0, 1'b0);
      check(flags(), 8'h01);
      check(rdData, 8'h66);
      core_u.access(Adj + 20'h00001, 1'b1, 1'b0, 1'b1);
      check(flags(), 8'h00);
   endtask : testRefused
   // A reset in mid-run clears the pulses, and reads work again after it.
   task automatic testReset();
      core_u.setState(8'h22, 1'b1, 1'b1);
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      check({6'h00, rdValid, accErr}, 8'h00);
      readAdj();
      check(core_u.seenData, 8'h66);
   endtask : testReset
   ////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      testsRun = 0;
      rstn = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      // Content is meaningless until state is set, so nothing is read.
      testAdd();
      testSub();
      testLive();
      testRefused();
      testReset();
      finish_test();
   end
   initial begin
      #100000;
      fails++;
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
